// >>> diasq_top.sv
// diasq_top: digital sequencer of a two-channel simultaneous incremental converter.
// assumes comparator outputs arrive asynchronously and software uses Avalon-MM.
//
// Functional notes
// - resolution accepted only from 7 to 13
// - resolution change halts both; restart needed
// - integrate lasts 2^(res+2) conversion counts
// - integrate plus gap never above 65535
// - period equals integrate plus gap counts
// - counters, timer and phases run from one conversion clock
// - signed result is two's complement, N bits
// - unsigned result spans 0 to 2^N-1
// - normal phase acquires on first phase
// - swapped phase acquires on second phase
// - counters, timer interrupt; counters ranked first
// - overrange saturates to extreme codes
module diasq_top #(
    parameter int CNT_STEP = diasq_pkg::CNT_IRQ_STEP
) (
    input wire logic i_clk, // system clock, 20 MHz
    input wire logic i_nrst, // synchronous reset, active low
    input wire logic [5:0] i_address, // avalon byte address
    input wire logic i_read, // avalon read
    input wire logic i_write, // avalon write
    input wire logic [31:0] i_writedata, // avalon write data
    output logic [31:0] o_readdata, // avalon read data
    output logic o_waitrequest, // avalon waitrequest
    input wire logic i_cmp_ch1, // comparator, channel 1, async
    input wire logic i_cmp_ch2, // comparator, channel 2, async
    output logic o_phi1_ch1, // integrator acquire phase, ch 1
    output logic o_phi2_ch1, // integrator transfer phase, ch 1
    output logic o_phi1_ch2, // integrator acquire phase, ch 2
    output logic o_phi2_ch2, // integrator transfer phase, ch 2
    output logic o_int_reset, // integrators held in reset
    output logic o_irq, // level interrupt
    output logic [1:0] o_irq_id // highest-priority pending source
);
    ////////////////////////////////////////////////////////////////////////////
    // elaboration check
    if (CNT_STEP < 1 || CNT_STEP > 256 || (CNT_STEP & (CNT_STEP - 1)) != 0) begin : g_chk
        $error("CNT_STEP must be a power of two from 1 to 256");
    end

    // integrate length 2^(res+2)
    function automatic logic [16:0] integ_len(input logic [3:0] res);
        integ_len = 17'h00001 << (res + 4'h2);
    endfunction

    // saturated count to formatted 32-bit result
    function automatic logic [31:0] fmt(input logic [13:0] n, input logic [3:0] res,
                                        input logic uns);
        logic [13:0] full;
        logic [13:0] sat;
        logic [13:0] half;
        full = 14'h0001 << res;
        half = 14'h0001 << (res - 4'h1);
        sat = (n >= full) ? full - 14'h0001 : n;
        if (uns)
            fmt = {18'h00000, sat};
        else
            fmt = 32'(signed'({1'b0, sat} - {1'b0, half}));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic run_r, uns_r, swap1_r, swap2_r;
    logic [3:0] res_r;
    logic [15:0] gap_r;
    logic [7:0] div_r;
    logic avail_r;
    logic [2:0] irq_st_r, irq_en_r;
    logic [31:0] data1_r, data2_r;
    logic wait_r;
    logic [31:0] rdata_r;
    diasq_pkg::diasq_state_t st_r;
    logic [15:0] pcnt_r;
    logic [7:0] dcnt_r;
    logic conv_en_r;
    logic ph_r;
    logic [13:0] n1_r, n2_r;
    logic [7:0] s1_r, s2_r;
    logic c1a_r, c1b_r, c2a_r, c2b_r;
    logic irq_r;
    logic [1:0] irq_id_r;
    logic phi1a_r, phi2a_r, phi1b_r, phi2b_r, intrst_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode; one wait cycle then a single ready cycle
    wire req = i_read | i_write;
    wire acc = req & ~wait_r;
    wire wr = i_write & acc;
    wire wr_ctrl = wr && i_address == diasq_pkg::OFS_CTRL;
    wire wr_res = wr && i_address == diasq_pkg::OFS_RES;
    wire wr_gap = wr && i_address == diasq_pkg::OFS_GAP;
    wire wr_div = wr && i_address == diasq_pkg::OFS_DIV;
    wire wr_clr = wr && i_address == diasq_pkg::OFS_IRQ_CLR;
    wire wr_en = wr && i_address == diasq_pkg::OFS_IRQ_EN;
    wire rd_d2 = i_read && acc && i_address == diasq_pkg::OFS_DATA2;
    wire [3:0] res_w = i_writedata[3:0];
    wire [16:0] integ = integ_len(res_r);
    // out-of-range resolutions and sums that would overflow the timer are ignored
    wire res_ok = i_writedata[31:4] == 28'h0 && res_w >= 4'(diasq_pkg::RES_MIN) &&
                  res_w <= 4'(diasq_pkg::RES_MAX) &&
                  {1'b0, integ_len(res_w)} + {2'b00, gap_r} <= 18'(diasq_pkg::TIMER_MAX);
    wire gap_ok = i_writedata[31:16] == 16'h0 && i_writedata[15:0] != 16'h0 &&
                  {1'b0, integ} + {2'b00, i_writedata[15:0]} <= 18'(diasq_pkg::TIMER_MAX);
    wire div_ok = i_writedata[31:8] == 24'h0 &&
                  i_writedata[7:0] >= 8'(diasq_pkg::DIV_MIN) &&
                  i_writedata[7:0] <= 8'(diasq_pkg::DIV_MAX);
    wire start = wr_ctrl & i_writedata[diasq_pkg::CTRL_RUN] & ~run_r;

    // read mux, unmapped offsets read as zero
    logic [31:0] rd_mux;
    always_comb begin
        unique case (i_address)
            diasq_pkg::OFS_CTRL: rd_mux = {28'h0, swap2_r, swap1_r, uns_r, run_r};
            diasq_pkg::OFS_RES: rd_mux = {28'h0, res_r};
            diasq_pkg::OFS_GAP: rd_mux = {16'h0, gap_r};
            diasq_pkg::OFS_DIV: rd_mux = {24'h0, div_r};
            diasq_pkg::OFS_STAT: rd_mux = {30'h0, avail_r, run_r};
            diasq_pkg::OFS_DATA1: rd_mux = data1_r;
            diasq_pkg::OFS_DATA2: rd_mux = data2_r;
            diasq_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_st_r};
            diasq_pkg::OFS_IRQ_EN: rd_mux = {29'h0, irq_en_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // bus handshake registers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= ~(req & wait_r);
            if (i_read && wait_r)
                rdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            run_r <= 1'b0;
            uns_r <= 1'b0;
            swap1_r <= 1'b0;
            swap2_r <= 1'b0;
            res_r <= diasq_pkg::RES_RST;
            gap_r <= diasq_pkg::GAP_RST;
            div_r <= diasq_pkg::DIV_RST;
        end else begin
            if (wr_ctrl) begin
                run_r <= i_writedata[diasq_pkg::CTRL_RUN];
                uns_r <= i_writedata[diasq_pkg::CTRL_UNS];
                swap1_r <= i_writedata[diasq_pkg::CTRL_SWAP1];
                swap2_r <= i_writedata[diasq_pkg::CTRL_SWAP2];
            end
            if (wr_res && res_ok) begin
                res_r <= res_w;
                run_r <= 1'b0;
            end
            if (wr_gap && gap_ok)
                gap_r <= i_writedata[15:0];
            if (wr_div && div_ok)
                div_r <= i_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion clock enable: the one tick drives counters, timer and phases
    always_ff @(posedge i_clk) begin
        if (!i_nrst || start) begin
            dcnt_r <= 8'h00;
            conv_en_r <= 1'b0;
        end else begin
            dcnt_r <= (dcnt_r >= div_r - 8'h01) ? 8'h00 : dcnt_r + 8'h01;
            conv_en_r <= dcnt_r >= div_r - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and period timer
    wire integ_end = st_r == diasq_pkg::ST_INTEG && conv_en_r && {1'b0, pcnt_r} == integ - 17'h1;
    // a gap shortened mid-run ends at once instead of wrapping the period timer
    wire gap_end = st_r == diasq_pkg::ST_GAP && conv_en_r && pcnt_r >= gap_r - 16'h1;
    // comparator decision once every four conversion counts
    wire decide = st_r == diasq_pkg::ST_INTEG && conv_en_r && pcnt_r[1:0] == 2'h3;
    wire step1 = decide & c1b_r & (s1_r == 8'(CNT_STEP - 1));
    wire step2 = decide & c2b_r & (s2_r == 8'(CNT_STEP - 1));
    always_ff @(posedge i_clk) begin
        if (!i_nrst || !run_r) begin
            st_r <= diasq_pkg::ST_IDLE;
            pcnt_r <= 16'h0;
        end else if (st_r == diasq_pkg::ST_IDLE) begin
            st_r <= diasq_pkg::ST_INTEG;
            pcnt_r <= 16'h0;
        end else if (integ_end) begin
            st_r <= diasq_pkg::ST_GAP;
            pcnt_r <= 16'h0;
        end else if (gap_end) begin
            st_r <= diasq_pkg::ST_INTEG;
            pcnt_r <= 16'h0;
        end else if (conv_en_r) begin
            pcnt_r <= pcnt_r + 16'h1;
        end
    end

    // comparator synchronisers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            {c1a_r, c1b_r, c2a_r, c2b_r} <= 4'h0;
        end else begin
            c1a_r <= i_cmp_ch1;
            c1b_r <= c1a_r;
            c2a_r <= i_cmp_ch2;
            c2b_r <= c2a_r;
        end
    end

    // positive-decision accumulators, cleared at each integrate start
    always_ff @(posedge i_clk) begin
        if (!i_nrst || st_r != diasq_pkg::ST_INTEG) begin
            n1_r <= 14'h0;
            n2_r <= 14'h0;
            s1_r <= 8'h0;
            s2_r <= 8'h0;
        end else if (decide) begin
            n1_r <= n1_r + {13'h0, c1b_r};
            n2_r <= n2_r + {13'h0, c2b_r};
            s1_r <= step1 ? 8'h0 : s1_r + {7'h0, c1b_r};
            s2_r <= step2 ? 8'h0 : s2_r + {7'h0, c2b_r};
        end
    end

    // final decision of the phase is folded in before the latch
    wire [13:0] n1_fin = n1_r + {13'h0, decide & c1b_r};
    wire [13:0] n2_fin = n2_r + {13'h0, decide & c2b_r};

    // both results latched on the same edge; a read of data 2 retires them
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            data1_r <= 32'h0;
            data2_r <= 32'h0;
            avail_r <= 1'b0;
        end else begin
            if (integ_end) begin
                data1_r <= fmt(n1_fin, res_r, uns_r);
                data2_r <= fmt(n2_fin, res_r, uns_r);
            end
            // set wins over the read that clears it
            avail_r <= integ_end | (avail_r & ~rd_d2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-phase integrator clocks; swap exchanges the phases per channel
    wire ph_nxt = (st_r == diasq_pkg::ST_INTEG) ? ph_r ^ conv_en_r : 1'b0;
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ph_r <= 1'b0;
            {phi1a_r, phi2a_r, phi1b_r, phi2b_r} <= 4'h0;
            intrst_r <= 1'b1;
        end else begin
            ph_r <= ph_nxt;
            phi1a_r <= swap1_r ? ph_nxt : ~ph_nxt;
            phi2a_r <= swap1_r ? ~ph_nxt : ph_nxt;
            phi1b_r <= swap2_r ? ph_nxt : ~ph_nxt;
            phi2b_r <= swap2_r ? ~ph_nxt : ph_nxt;
            intrst_r <= st_r != diasq_pkg::ST_INTEG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write-one clear, enable mask
    wire [2:0] irq_set = {integ_end, step2, step1};
    wire [2:0] irq_st_nxt = irq_set | (irq_st_r & ~(wr_clr ? i_writedata[2:0] : 3'h0));
    wire [2:0] irq_act = irq_st_nxt & irq_en_r;
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            irq_st_r <= 3'h0;
            irq_en_r <= 3'h0;
            irq_r <= 1'b0;
            irq_id_r <= diasq_pkg::IRQ_ID_NONE;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (wr_en)
                irq_en_r <= i_writedata[2:0];
            irq_r <= |irq_act;
            // counters ranked ahead of the period timer
            irq_id_r <= irq_act[diasq_pkg::IRQ_CNT1] ? diasq_pkg::IRQ_ID_CNT1 :
                        irq_act[diasq_pkg::IRQ_CNT2] ? diasq_pkg::IRQ_ID_CNT2 :
                        irq_act[diasq_pkg::IRQ_TMR] ? diasq_pkg::IRQ_ID_TMR :
                        diasq_pkg::IRQ_ID_NONE;
        end
    end

    assign o_readdata = rdata_r;
    assign o_waitrequest = wait_r;
    assign o_phi1_ch1 = phi1a_r;
    assign o_phi2_ch1 = phi2a_r;
    assign o_phi1_ch2 = phi1b_r;
    assign o_phi2_ch2 = phi2b_r;
    assign o_int_reset = intrst_r;
    assign o_irq = irq_r;
    assign o_irq_id = irq_id_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_res_write;
        wr_res && res_ok && run_r;
    endsequence
    a_res_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
        res_r >= 4'(diasq_pkg::RES_MIN) && res_r <= 4'(diasq_pkg::RES_MAX))
        else $error("resolution out of range");
    a_res_halts: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_res_write |=> !run_r ##1 st_r == diasq_pkg::ST_IDLE)
        else $error("resolution change did not halt");
    a_timer_fits: assert property (@(posedge i_clk) disable iff (!i_nrst)
        {1'b0, integ} + {2'b00, gap_r} <= 18'(diasq_pkg::TIMER_MAX) && gap_r != 16'h0)
        else $error("period exceeds timer");
    a_integ_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
        st_r == diasq_pkg::ST_INTEG |-> {1'b0, pcnt_r} < integ)
        else $error("integrate phase too long");
    a_gap_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
        gap_end |=> st_r == diasq_pkg::ST_INTEG && pcnt_r == 16'h0)
        else $error("gap did not return to integrate");
    a_latch_both: assert property (@(posedge i_clk) disable iff (!i_nrst)
        integ_end |=> avail_r && data1_r == fmt($past(n1_fin), $past(res_r), $past(uns_r)) &&
                      data2_r == fmt($past(n2_fin), $past(res_r), $past(uns_r)) &&
                      irq_st_r[diasq_pkg::IRQ_TMR])
        else $error("results not latched together");
    a_phase_swap: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $stable(swap1_r) && st_r == diasq_pkg::ST_INTEG |=> (phi1a_r == ($past(swap1_r) == ph_r)))
        else $error("channel 1 phase selection wrong");
    a_irq_prio: assert property (@(posedge i_clk) disable iff (!i_nrst)
        irq_act[diasq_pkg::IRQ_CNT1] |=> o_irq && o_irq_id == diasq_pkg::IRQ_ID_CNT1)
        else $error("counter interrupt not ranked first");
    a_div_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
        div_r >= 8'(diasq_pkg::DIV_MIN) && div_r <= 8'(diasq_pkg::DIV_MAX))
        else $error("conversion clock divider out of range");
    a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_nrst)
        req && wait_r |=> !o_waitrequest)
        else $error("bus not answered in one cycle");
endmodule

// >>> diasq_pkg.sv
// diasq_pkg: constants shared by the two-channel incremental converter sequencer.
// assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package diasq_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // resolution limits and format
    localparam int RES_MIN = 7;
    localparam int RES_MAX = 13;
    localparam logic [3:0] RES_RST = 4'hA;
    localparam int TIMER_MAX = 65535;
    localparam logic [15:0] GAP_RST = 16'h0021;
    localparam int DEC_PER_TICK = 4;
    localparam int CNT_IRQ_STEP = 64;
    ////////////////////////////////////////////////////////////////////////////
    // clock rates, conversion clock window
    localparam longint SYS_HZ = 20000000;
    localparam longint CONV_MIN_HZ = 125000;
    localparam longint CONV_MAX_HZ = 8000000;
    localparam int DIV_MIN = int'((SYS_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ);
    localparam int DIV_MAX = int'(SYS_HZ / CONV_MIN_HZ);
    localparam logic [7:0] DIV_RST = 8'h0A;
    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_RES = 6'h04;
    localparam logic [5:0] OFS_GAP = 6'h08;
    localparam logic [5:0] OFS_DIV = 6'h0C;
    localparam logic [5:0] OFS_STAT = 6'h10;
    localparam logic [5:0] OFS_DATA1 = 6'h14;
    localparam logic [5:0] OFS_DATA2 = 6'h18;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
    localparam logic [5:0] OFS_IRQ_CLR = 6'h20;
    localparam logic [5:0] OFS_IRQ_EN = 6'h24;
    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_UNS = 1;
    localparam int CTRL_SWAP1 = 2;
    localparam int CTRL_SWAP2 = 3;
    localparam int STAT_RUN = 0;
    localparam int STAT_AVAIL = 1;
    localparam int IRQ_CNT1 = 0;
    localparam int IRQ_CNT2 = 1;
    localparam int IRQ_TMR = 2;
    localparam logic [1:0] IRQ_ID_NONE = 2'h0;
    localparam logic [1:0] IRQ_ID_CNT1 = 2'h1;
    localparam logic [1:0] IRQ_ID_CNT2 = 2'h2;
    localparam logic [1:0] IRQ_ID_TMR = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_GAP} diasq_state_t;
endpackage

// >>> diasq_cmp_model.sv
// diasq_cmp_model: one integrator and comparator on the far side of the sequencer.
// assumes its phase and reset inputs come from the sequencer on the same clock.
module diasq_cmp_model (
    input wire logic i_clk, // system clock
    input wire logic i_phi1, // acquire phase of this channel
    input wire logic i_int_reset, // integrator held in reset
    input wire logic i_level, // 1 input above range, 0 below range
    output logic o_cmp // comparator decision
);
    timeunit 1ns;
    timeprecision 100ps;
    logic phi1_r = 1'b0;
    logic rst_r = 1'b1;
    logic cmp_r = 1'b0;
    assign o_cmp = cmp_r;
    //////////////////////////////////////////////////////////////////
    // wanders every clock in reset, so a decision taken outside integrate
    // shows; otherwise follows the input at each acquire phase
    always @(posedge i_clk) begin
        phi1_r <= i_phi1;
        rst_r <= i_int_reset;
        if (i_int_reset) begin
            cmp_r <= ~cmp_r;
        end else if (rst_r || (i_phi1 && !phi1_r)) begin
            cmp_r <= i_level;
        end
    end
endmodule

// >>> diasq_top_test.sv
// diasq_top_test: self-checking bench of the converter sequencer.
// assumes diasq_pkg, diasq_top and diasq_cmp_model are compiled first.
module diasq_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 3;
    localparam int RES = 7;
    // gap covers 260 cpu clocks, the cpu running at the system clock
    localparam int GAP = (260 + DIV - 1) / DIV;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [5:0] i_address = 6'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest, i_cmp_ch1, i_cmp_ch2, o_int_reset, o_irq;
    logic o_phi1_ch1, o_phi2_ch1, o_phi1_ch2, o_phi2_ch2;
    logic [1:0] o_irq_id;
    logic lvl1 = 1'b0;
    logic lvl2 = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int ph_bad = 0;
    diasq_top #(.CNT_STEP(4)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_cmp_ch1(i_cmp_ch1),
        .i_cmp_ch2(i_cmp_ch2), .o_phi1_ch1(o_phi1_ch1), .o_phi2_ch1(o_phi2_ch1),
        .o_phi1_ch2(o_phi1_ch2), .o_phi2_ch2(o_phi2_ch2), .o_int_reset(o_int_reset),
        .o_irq(o_irq), .o_irq_id(o_irq_id));
    diasq_cmp_model cmp1_u (.i_clk(i_clk), .i_phi1(o_phi1_ch1), .i_int_reset(o_int_reset),
        .i_level(lvl1), .o_cmp(i_cmp_ch1));
    diasq_cmp_model cmp2_u (.i_clk(i_clk), .i_phi1(o_phi1_ch2), .i_int_reset(o_int_reset),
        .i_level(lvl2), .o_cmp(i_cmp_ch2));
    //////////////////////////////////////////////////////////////////
    // 20 MHz clock and hang guard; a whole run needs well under 10k cycles
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    //////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon access; request held until the rising edge that sees
    // waitrequest low, data taken and request dropped at that same edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_clk);
        i_write <= wr;
        i_read <= ~wr;
        i_address <= a;
        i_writedata <= d;
        @(posedge i_clk);
        while (o_waitrequest !== 1'b0) begin
            @(posedge i_clk);
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic pins(output logic [31:0] v);
        repeat (3) @(negedge i_clk);
        v = {26'h0, o_irq_id, o_phi1_ch1, o_phi2_ch1, o_phi1_ch2, o_phi2_ch2, o_irq, o_int_reset};
    endtask
    // no local limit: the cycle guard ends a hang
    task automatic wait_rst(input logic lvl);
        @(negedge i_clk);
        while (o_int_reset !== lvl) begin
            @(negedge i_clk);
        end
    endtask
    // length in clocks of the current integrator reset level
    task automatic span(output int len);
        logic lvl;
        lvl = o_int_reset;
        len = 0;
        while (o_int_reset === lvl) begin
            if (o_phi1_ch1 === o_phi1_ch2 || o_phi1_ch1 === o_phi2_ch1) ph_bad++;
            len++;
            @(negedge i_clk);
        end
    endtask
    //////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] v;
        pins(v);
        chk(v, 32'h029);
        rdc(diasq_pkg::OFS_CTRL, 32'h0);
        rdc(diasq_pkg::OFS_RES, 32'hA);
        rdc(diasq_pkg::OFS_GAP, 32'h21);
        rdc(diasq_pkg::OFS_DIV, 32'hA);
        rdc(diasq_pkg::OFS_IRQ_EN, 32'h0);
        rdc(6'h3C, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_limits();
        wr(diasq_pkg::OFS_RES, 32'h6);
        rdc(diasq_pkg::OFS_RES, 32'hA);
        wr(diasq_pkg::OFS_RES, 32'hE);
        rdc(diasq_pkg::OFS_RES, 32'hA);
        wr(diasq_pkg::OFS_RES, 32'hD);
        rdc(diasq_pkg::OFS_RES, 32'hD);
        wr(diasq_pkg::OFS_GAP, 32'h8000);
        rdc(diasq_pkg::OFS_GAP, 32'h21);
        wr(diasq_pkg::OFS_GAP, 32'h7FFF);
        rdc(diasq_pkg::OFS_GAP, 32'h7FFF);
        wr(diasq_pkg::OFS_GAP, 32'h0);
        rdc(diasq_pkg::OFS_GAP, 32'h7FFF);
        wr(diasq_pkg::OFS_DIV, 32'h2);
        rdc(diasq_pkg::OFS_DIV, 32'hA);
        wr(diasq_pkg::OFS_RES, 32'(RES));
        rdc(diasq_pkg::OFS_RES, 32'(RES));
        wr(diasq_pkg::OFS_GAP, 32'(GAP));
        wr(diasq_pkg::OFS_DIV, 32'(DIV));
        $display("test limits done");
    endtask
    task automatic t_phases();
        logic [31:0] v;
        wr(diasq_pkg::OFS_CTRL, 32'h8);
        pins(v);
        chk({28'h0, v[5:2]}, 32'h9);
        wr(diasq_pkg::OFS_CTRL, 32'h4);
        pins(v);
        chk({28'h0, v[5:2]}, 32'h6);
        $display("test phases done");
    endtask
    // one period with the given phase swaps; both results latched together
    task automatic t_conv(input logic [1:0] sw, input logic uns, input logic l1,
        input logic l2, input logic [31:0] e1, input logic [31:0] e2);
        int len;
        lvl1 <= l1;
        lvl2 <= l2;
        ph_bad = 0;
        wr(diasq_pkg::OFS_CTRL, {28'h0, sw, uns, 1'b1});
        wait_rst(1'b0);
        span(len);
        chk(32'(len), 32'((2 ** (RES + 2)) * DIV));
        span(len);
        chk(32'(len), 32'(GAP * DIV));
        chk(32'(ph_bad), 32'h0);
        rdc(diasq_pkg::OFS_STAT, 32'h3);
        rdc(diasq_pkg::OFS_DATA1, e1);
        rdc(diasq_pkg::OFS_DATA2, e2);
        rdc(diasq_pkg::OFS_STAT, 32'h1);
        wr(diasq_pkg::OFS_CTRL, 32'h8);
        $display("test conversion done");
    endtask
    task automatic t_irq();
        logic [31:0] v;
        rdc(diasq_pkg::OFS_IRQ_STAT, 32'h7);
        pins(v);
        chk({31'h0, v[1]}, 32'h0);
        wr(diasq_pkg::OFS_IRQ_EN, 32'h7);
        rdc(diasq_pkg::OFS_IRQ_EN, 32'h7);
        pins(v);
        chk(v & 32'hC2, 32'h42);
        wr(diasq_pkg::OFS_IRQ_CLR, 32'h1);
        pins(v);
        chk(v & 32'hC2, 32'h82);
        wr(diasq_pkg::OFS_IRQ_CLR, 32'h2);
        pins(v);
        chk(v & 32'hC2, 32'hC2);
        wr(diasq_pkg::OFS_IRQ_CLR, 32'h4);
        rdc(diasq_pkg::OFS_IRQ_STAT, 32'h0);
        pins(v);
        chk(v & 32'hC2, 32'h0);
        $display("test interrupts done");
    endtask
    // a resolution write mid-run stops both channels until restarted
    task automatic t_halt();
        int n;
        wr(diasq_pkg::OFS_CTRL, 32'h9);
        wait_rst(1'b0);
        wr(diasq_pkg::OFS_RES, 32'h8);
        rdc(diasq_pkg::OFS_STAT, 32'h0);
        rdc(diasq_pkg::OFS_CTRL, 32'h8);
        n = 0;
        repeat (2000) begin
            @(negedge i_clk);
            if (o_int_reset !== 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        wr(diasq_pkg::OFS_CTRL, 32'h9);
        rdc(diasq_pkg::OFS_STAT, 32'h1);
        $display("test halt done");
    endtask
    //////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset();
        t_limits();
        t_phases();
        t_conv(2'b10, 1'b0, 1'b1, 1'b0, 32'(2 ** (RES - 1) - 1), 32'(-(2 ** (RES - 1))));
        t_conv(2'b01, 1'b1, 1'b0, 1'b1, 32'h0, 32'(2 ** RES - 1));
        t_irq();
        t_halt();
        results();
    end
endmodule
